// ==== hdl/rpe_engine.sv ====
`timescale 1ns/1ps
module rpe_engine
   import rpe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic radio_activate,
   input wire logic primary_receiver,
   input wire logic engine_enable,
   input wire logic auto_ack_enable,
   input wire logic [3:0] retry_delay,
   input wire logic [3:0] retry_limit,
   input wire logic [5:0] pipe_enable_bits,
   input rpe_addr_cfg_t pipe_rx_address,
   input wire logic tx_fifo_has_packet,
   input wire logic ack_payload_pending,
   input wire logic air_addr_match,
   input wire logic air_rx_busy,
   input rpe_rx_frame_t air_rx_frame,
   input wire logic air_tx_finished,
   output logic air_tx_start,
   output logic air_tx_is_ack,
   output logic air_ack_with_payload,
   output logic [39:0] air_tx_address,
   output logic [2:0] rx_pipe,
   output logic rx_fifo_load,
   output logic tx_fifo_pop,
   output logic ack_payload_pop,
   output logic crc_force_on,
   output rpe_events_t events,
   output logic radio_interrupt,
   output rpe_mode_t mode,
   output logic [3:0] retry_count
);

   // ************************************************
   // Activate synchroniser and pipe decode
   // ************************************************
   logic act_s;
   logic hit;
   logic [2:0] hit_pipe;

   rpe_sync u_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(radio_activate),
      .q(act_s)
   );

   rpe_pipe_match u_match (
      .cfg(pipe_rx_address),
      .pipe_en(pipe_enable_bits),
      .addr(air_rx_frame.addr),
      .hit(hit),
      .pipe(hit_pipe)
   );

   function automatic logic [39:0] pipe_addr(input rpe_addr_cfg_t c, input logic [2:0] p);
      logic [7:0] lo;
      lo = c.low0;
      unique case (p)
         3'h1: lo = c.low1;
         3'h2: lo = c.low2;
         3'h3: lo = c.low3;
         3'h4: lo = c.low4;
         3'h5: lo = c.low5;
         default: lo = c.low0;
      endcase
      return {c.upper, lo};
   endfunction : pipe_addr

   // ************************************************
   // Mode machine
   // ************************************************
   typedef enum logic [3:0] {
      ST_IDLE,
      ST_STBY2,
      ST_TX_SETTLE,
      ST_TX_SEND,
      ST_ACK_WAIT,
      ST_ACK_RECV,
      ST_RETRY_WAIT,
      ST_RX_SEARCH,
      ST_RX_ACK_SEND
   } rpe_state_t;

   rpe_state_t st_r, st_nxt;
   logic [19:0] tmr_r, tmr_nxt;
   logic [3:0] rc_r, rc_nxt;
   logic [1:0] last_pid_r [6];
   logic [1:0] last_pid_nxt [6];
   logic [5:0] seen_r, seen_nxt;
   logic [5:0] ackpay_r, ackpay_nxt;
   logic [2:0] pipe_r, pipe_nxt;
   rpe_events_t ev_nxt;
   logic irq_nxt;
   logic start_nxt, is_ack_nxt, withpay_nxt, load_nxt, pop_nxt, apop_nxt;
   logic [39:0] txa_nxt;
   rpe_mode_t mode_nxt;
   logic dup;
   logic [19:0] retry_cyc;

   always_comb begin
      st_nxt = st_r;
      tmr_nxt = tmr_r;
      rc_nxt = rc_r;
      last_pid_nxt = last_pid_r;
      seen_nxt = seen_r;
      ackpay_nxt = ackpay_r;
      pipe_nxt = pipe_r;
      ev_nxt = '0;
      start_nxt = 1'b0;
      is_ack_nxt = air_tx_is_ack;
      withpay_nxt = air_ack_with_payload;
      load_nxt = 1'b0;
      pop_nxt = 1'b0;
      apop_nxt = 1'b0;
      txa_nxt = air_tx_address;
      // Step of 256 us per code, code 0 meaning one step
      retry_cyc = 20'(({16'h0, retry_delay} + 20'h1) * 20'(RETRY_STEP_CYC));
      dup = seen_r[hit_pipe] && (last_pid_r[hit_pipe] == air_rx_frame.pid);
      if (tmr_r != 20'h0) begin
         tmr_nxt = tmr_r - 20'h1;
      end
      unique case (st_r)
         ST_IDLE: begin
            if (act_s && engine_enable) begin
               if (primary_receiver) begin
                  st_nxt = ST_RX_SEARCH;
               end else if (tx_fifo_has_packet) begin
                  st_nxt = ST_TX_SETTLE;
                  tmr_nxt = 20'(TX_START_CYC);
                  rc_nxt = 4'h0;
               end else begin
                  st_nxt = ST_STBY2;
               end
            end
         end
         ST_STBY2: begin
            if (!act_s) begin
               st_nxt = ST_IDLE;
            end else if (tx_fifo_has_packet) begin
               st_nxt = ST_TX_SETTLE;
               tmr_nxt = 20'(TX_START_CYC);
               rc_nxt = 4'h0;
            end
         end
         ST_TX_SETTLE: begin
            if (tmr_r == 20'h0) begin
               st_nxt = ST_TX_SEND;
               start_nxt = 1'b1;
               is_ack_nxt = 1'b0;
               withpay_nxt = 1'b0;
            end
         end
         ST_TX_SEND: begin
            if (air_tx_finished) begin
               st_nxt = ST_ACK_WAIT;
               tmr_nxt = 20'(ACK_WAIT_CYC);
            end
         end
         ST_ACK_WAIT: begin
            if (air_addr_match) begin
               st_nxt = ST_ACK_RECV;
            end else if (tmr_r == 20'h0) begin
               st_nxt = ST_RETRY_WAIT;
               tmr_nxt = retry_cyc;
            end
         end
         ST_ACK_RECV: begin
            if (air_rx_frame.valid) begin
               if (air_rx_frame.crc_ok) begin
                  ev_nxt.tx_done_event = 1'b1;
                  ev_nxt.rx_ready_event = air_rx_frame.has_payload;
                  load_nxt = air_rx_frame.has_payload;
                  pop_nxt = 1'b1;
                  st_nxt = ST_IDLE;
               end else begin
                  st_nxt = ST_RETRY_WAIT;
                  tmr_nxt = retry_cyc;
               end
            end
         end
         ST_RETRY_WAIT: begin
            if (tmr_r == 20'h0) begin
               if (rc_r >= retry_limit) begin
                  ev_nxt.retry_limit_event = 1'b1;
                  st_nxt = ST_IDLE;
               end else begin
                  rc_nxt = rc_r + 4'h1;
                  st_nxt = ST_TX_SEND;
                  start_nxt = 1'b1;
                  is_ack_nxt = 1'b0;
                  withpay_nxt = 1'b0;
               end
            end
         end
         ST_RX_SEARCH: begin
            // Modem busy locks out every pipe, the frame's own included, until the frame ends
            if (!act_s) begin
               st_nxt = ST_IDLE;
            end else if (air_rx_frame.valid && !air_rx_busy && air_rx_frame.crc_ok && hit) begin
               pipe_nxt = hit_pipe;
               if (auto_ack_enable) begin
                  if (ackpay_r[hit_pipe]) begin
                     ev_nxt.tx_done_event = 1'b1;
                     ackpay_nxt[hit_pipe] = 1'b0;
                     apop_nxt = 1'b1;
                  end
                  if (!dup) begin
                     load_nxt = 1'b1;
                     ev_nxt.rx_ready_event = 1'b1;
                  end
                  seen_nxt[hit_pipe] = 1'b1;
                  last_pid_nxt[hit_pipe] = air_rx_frame.pid;
                  if (!air_rx_frame.no_ack) begin
                     st_nxt = ST_RX_ACK_SEND;
                     start_nxt = 1'b1;
                     is_ack_nxt = 1'b1;
                     withpay_nxt = ack_payload_pending;
                     ackpay_nxt[hit_pipe] = ack_payload_pending;
                     txa_nxt = pipe_addr(pipe_rx_address, hit_pipe);
                  end
               end else begin
                  load_nxt = 1'b1;
                  ev_nxt.rx_ready_event = 1'b1;
               end
            end
         end
         ST_RX_ACK_SEND: begin
            if (air_tx_finished) begin
               st_nxt = ST_RX_SEARCH;
            end
         end
         default: st_nxt = ST_IDLE;
      endcase
      irq_nxt = |ev_nxt;
      unique case (st_nxt)
         ST_STBY2, ST_RETRY_WAIT: mode_nxt = RPE_MODE_STBY2;
         ST_TX_SETTLE, ST_TX_SEND, ST_RX_ACK_SEND: mode_nxt = RPE_MODE_TX;
         ST_ACK_WAIT, ST_ACK_RECV, ST_RX_SEARCH: mode_nxt = RPE_MODE_RX;
         default: mode_nxt = RPE_MODE_STBY1;
      endcase
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= ST_IDLE;
         tmr_r <= 20'h0;
         rc_r <= 4'h0;
         for (int i = 0; i < 6; i++) begin
            last_pid_r[i] <= PID_RESET;
         end
         seen_r <= 6'h0;
         ackpay_r <= 6'h0;
         pipe_r <= 3'h0;
         events <= '0;
         radio_interrupt <= 1'b0;
         air_tx_start <= 1'b0;
         air_tx_is_ack <= 1'b0;
         air_ack_with_payload <= 1'b0;
         air_tx_address <= 40'h0;
         rx_pipe <= 3'h0;
         rx_fifo_load <= 1'b0;
         tx_fifo_pop <= 1'b0;
         ack_payload_pop <= 1'b0;
         crc_force_on <= 1'b0;
         mode <= RPE_MODE_STBY1;
         retry_count <= 4'h0;
      end else begin
         st_r <= st_nxt;
         tmr_r <= tmr_nxt;
         rc_r <= rc_nxt;
         last_pid_r <= last_pid_nxt;
         seen_r <= seen_nxt;
         ackpay_r <= ackpay_nxt;
         pipe_r <= pipe_nxt;
         events <= ev_nxt;
         radio_interrupt <= irq_nxt;
         air_tx_start <= start_nxt;
         air_tx_is_ack <= is_ack_nxt;
         air_ack_with_payload <= withpay_nxt;
         air_tx_address <= txa_nxt;
         rx_pipe <= pipe_nxt;
         rx_fifo_load <= load_nxt;
         tx_fifo_pop <= pop_nxt;
         ack_payload_pop <= apop_nxt;
         crc_force_on <= engine_enable;
         mode <= mode_nxt;
         retry_count <= rc_nxt;
      end
   end

endmodule : rpe_engine

// ==== hdl/rpe_pipe_match.sv ====
`timescale 1ns/1ps
module rpe_pipe_match
   import rpe_pkg::*;
(
   input rpe_addr_cfg_t cfg,
   input wire logic [5:0] pipe_en,
   input wire logic [39:0] addr,
   output logic hit,
   output logic [2:0] pipe
);
   logic [5:0] m;
   logic [7:0] lows [6];

   // ************************************************
   // Six comparators side by side
   // ************************************************
   always_comb begin
      lows[0] = cfg.low0;
      lows[1] = cfg.low1;
      lows[2] = cfg.low2;
      lows[3] = cfg.low3;
      lows[4] = cfg.low4;
      lows[5] = cfg.low5;
      for (int i = 0; i < 6; i++) begin
         m[i] = pipe_en[i] && (addr[39:8] == cfg.upper) && (addr[7:0] == lows[i]);
      end
      hit = 1'b0;
      pipe = 3'h0;
      // Lowest pipe wins so one packet lands on exactly one pipe
      for (int i = 5; i >= 0; i--) begin
         if (m[i]) begin
            hit = 1'b1;
            pipe = 3'(i);
         end
      end
   end
endmodule : rpe_pipe_match

// ==== hdl/rpe_pkg.sv ====
package rpe_pkg;

   // ************************************************
   // Timing
   // ************************************************
   localparam int unsigned CLK_MHZ = 50;
   localparam int unsigned ACT_HOLD_US = 10;
   localparam int unsigned TX_START_US = 210;
   localparam int unsigned RETRY_STEP_US = 256;
   localparam int unsigned ACK_WAIT_US = 256;
   localparam int unsigned ACT_HOLD_CYC = ACT_HOLD_US * CLK_MHZ;
   localparam int unsigned TX_START_CYC = TX_START_US * CLK_MHZ;
   localparam int unsigned RETRY_STEP_CYC = RETRY_STEP_US * CLK_MHZ;
   localparam int unsigned ACK_WAIT_CYC = ACK_WAIT_US * CLK_MHZ;

   // ************************************************
   // Configuration
   // ************************************************
   localparam int unsigned NUM_PIPES = 6;
   localparam logic [5:0] PIPE_EN_RESET = 6'h03;
   localparam logic [3:0] RETRY_DELAY_RESET = 4'h0;
   localparam logic [3:0] RETRY_LIMIT_RESET = 4'h3;
   localparam logic [1:0] PID_RESET = 2'h0;

   typedef struct packed {
      logic [31:0] upper;
      logic [7:0] low0;
      logic [7:0] low1;
      logic [7:0] low2;
      logic [7:0] low3;
      logic [7:0] low4;
      logic [7:0] low5;
   } rpe_addr_cfg_t;

   // Air side: a received frame summary from the modem
   typedef struct packed {
      logic valid;
      logic [39:0] addr;
      logic [1:0] pid;
      logic no_ack;
      logic has_payload;
      logic crc_ok;
   } rpe_rx_frame_t;

   typedef struct packed {
      logic tx_done_event;
      logic rx_ready_event;
      logic retry_limit_event;
   } rpe_events_t;

   typedef enum logic [1:0] {
      RPE_MODE_STBY1,
      RPE_MODE_STBY2,
      RPE_MODE_TX,
      RPE_MODE_RX
   } rpe_mode_t;

endpackage : rpe_pkg

// ==== hdl/rpe_sync.sv ====
`timescale 1ns/1ps
module rpe_sync
   import rpe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic s1_r;
   logic s1_nxt;
   logic q_nxt;

   always_comb begin
      s1_nxt = d;
      q_nxt = s1_r;
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= 1'b0;
         q <= 1'b0;
      end else begin
         s1_r <= s1_nxt;
         q <= q_nxt;
      end
   end
endmodule : rpe_sync

// ==== tb/rpe_air_peer.sv ====
`timescale 1ns/1ps
module rpe_air_peer
   import rpe_pkg::*;
(
   input wire logic clk,
   input wire logic air_tx_start,
   input wire logic air_tx_is_ack,
   input wire logic [39:0] air_tx_address,
   input wire logic [1:0] ack_mode,
   output logic air_tx_finished,
   output logic air_addr_match,
   output rpe_rx_frame_t air_rx_frame
);
   // ****
   // Far transceiver
   // ****
   logic [39:0] dest;
   initial begin
      air_tx_finished = 1'b0;
      air_addr_match = 1'b0;
      air_rx_frame = '0;
   end
   // Idle fields flip every cycle so a stale value never passes for a frame
   always @(posedge clk) begin
      if (!air_rx_frame.valid) begin
         air_rx_frame[44:0] <= ~air_rx_frame[44:0];
      end
   end
   task automatic send(input logic [39:0] a, input logic [1:0] p, input logic na, input logic pay, input logic ok);
      @(posedge clk);
      #1;
      air_rx_frame = {1'b1, a, p, na, pay, ok};
      @(posedge clk);
      #1;
      air_rx_frame.valid = 1'b0;
   endtask : send
   // Ack mode 0 loses the ack, 1 sends it empty, 2 with payload
   always begin
      @(posedge clk);
      if (air_tx_start) begin
         dest = air_tx_address;
         repeat (20) @(posedge clk);
         #1 air_tx_finished = 1'b1;
         @(posedge clk);
         #1 air_tx_finished = 1'b0;
         if (!air_tx_is_ack && ack_mode != 2'h0) begin
            repeat (30) @(posedge clk);
            #1 air_addr_match = 1'b1;
            send(dest, 2'h0, 1'b0, ack_mode[1], 1'b1);
            air_addr_match = 1'b0;
         end
      end
   end
endmodule : rpe_air_peer

// ==== tb/rpe_engine_chk.sv ====
`timescale 1ns/1ps
module rpe_engine_chk
   import rpe_pkg::*;
(
   input wire logic clk,
   input wire logic rst_b,
   input wire logic primary_receiver,
   input wire logic engine_enable,
   input wire logic auto_ack_enable,
   input wire logic [3:0] retry_limit,
   input wire logic [5:0] pipe_enable_bits,
   input rpe_addr_cfg_t pipe_rx_address,
   input rpe_rx_frame_t air_rx_frame,
   input wire logic air_tx_start,
   input wire logic air_tx_is_ack,
   input wire logic [39:0] air_tx_address,
   input wire logic [2:0] rx_pipe,
   input wire logic rx_fifo_load,
   input wire logic tx_fifo_pop,
   input wire logic crc_force_on,
   input rpe_events_t events,
   input wire logic radio_interrupt,
   input rpe_mode_t mode,
   input wire logic [3:0] retry_count
);
   // ****
   // Protocol checks
   // ****
   logic [7:0] pipe_low;
   assign pipe_low = pipe_rx_address[47 - 8 * rx_pipe -: 8];
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_ptx_done;
      !primary_receiver && events.tx_done_event;
   endsequence
   sequence s_prx_load;
      primary_receiver && rx_fifo_load;
   endsequence
   // Without auto-ack no acknowledgement is owed
   sequence s_prx_acked;
      primary_receiver && auto_ack_enable && rx_fifo_load;
   endsequence
   chk_irq_is_or:
      assert property (radio_interrupt == (|events))
      else $error("interrupt does not match events");
   chk_crc_forced:
      assert property (1'b1 |=> crc_force_on == $past(engine_enable))
      else $error("crc force not following engine enable");
   chk_done_pops:
      assert property (s_ptx_done |-> tx_fifo_pop && events.rx_ready_event == rx_fifo_load)
      else $error("transmit done without pop");
   chk_payload_both:
      assert property (!primary_receiver && events.rx_ready_event |-> events.tx_done_event
         ##[0:1] mode == RPE_MODE_STBY1)
      else $error("ack payload events wrong");
   chk_limit_stop:
      assert property (events.retry_limit_event |-> retry_count == retry_limit && !tx_fifo_pop
         ##[0:1] mode == RPE_MODE_STBY1)
      else $error("retry limit ending wrong");
   chk_load_ready:
      assert property (s_prx_load |-> events.rx_ready_event && pipe_enable_bits[rx_pipe])
      else $error("load without ready or on disabled pipe");
   chk_ack_follows:
      assert property (s_prx_acked |-> $past(air_rx_frame.no_ack) or ##[0:3] (air_tx_start && air_tx_is_ack))
      else $error("no acknowledgement sent");
   chk_ack_address:
      assert property (primary_receiver && air_tx_start && air_tx_is_ack
         |-> air_tx_address == {pipe_rx_address.upper, pipe_low})
      else $error("acknowledgement address wrong");
endmodule : rpe_engine_chk

bind rpe_engine rpe_engine_chk u_chk (.clk, .rst_b, .primary_receiver, .engine_enable, .auto_ack_enable, .retry_limit,
   .pipe_enable_bits, .pipe_rx_address, .air_rx_frame, .air_tx_start, .air_tx_is_ack, .air_tx_address,
   .rx_pipe, .rx_fifo_load, .tx_fifo_pop, .crc_force_on, .events, .radio_interrupt, .mode, .retry_count);

// ==== tb/tb_rpe_engine.sv ====
`timescale 1ns/1ps
module tb_rpe_engine
   import rpe_pkg::*;
;
   // ****
   // Stimulus and checking
   // ****
   logic clk, rst_b, radio_activate, primary_receiver, tx_fifo_has_packet, ack_payload_pending, air_rx_busy;
   logic air_addr_match, air_tx_finished, air_tx_start, air_tx_is_ack, air_ack_with_payload;
   logic engine_enable, auto_ack_enable;
   logic rx_fifo_load, tx_fifo_pop, ack_payload_pop, crc_force_on, radio_interrupt;
   logic [3:0] retry_delay, retry_limit, retry_count;
   logic [5:0] pipe_enable_bits;
   logic [1:0] ack_mode;
   logic [39:0] air_tx_address;
   logic [2:0] rx_pipe;
   rpe_addr_cfg_t pipe_rx_address;
   rpe_rx_frame_t air_rx_frame;
   rpe_events_t events;
   rpe_mode_t mode;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;

   rpe_engine DUT (.clk, .rst_b, .radio_activate, .primary_receiver, .engine_enable, .auto_ack_enable,
      .retry_delay, .retry_limit, .pipe_enable_bits, .pipe_rx_address, .tx_fifo_has_packet, .ack_payload_pending,
      .air_addr_match, .air_rx_busy, .air_rx_frame, .air_tx_finished, .air_tx_start, .air_tx_is_ack,
      .air_ack_with_payload, .air_tx_address, .rx_pipe, .rx_fifo_load, .tx_fifo_pop, .ack_payload_pop,
      .crc_force_on, .events, .radio_interrupt, .mode, .retry_count);
   rpe_air_peer peer (.clk, .air_tx_start, .air_tx_is_ack, .air_tx_address, .ack_mode, .air_tx_finished,
      .air_addr_match, .air_rx_frame);

   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // The run needs about 84000 cycles; the ceiling only stops a hang
   always @(posedge clk) begin
      cyc++;
      if (cyc == 95000) begin
         num_errors++;
         complete_run();
      end
   end

   task automatic check(input logic [47:0] got, input logic [47:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : complete_run
   // One cycle; pops standing now empty the FIFOs, so no one-cycle pulse slips past
   task automatic tick;
      if (tx_fifo_pop) tx_fifo_has_packet = 1'b0;
      if (ack_payload_pop) ack_payload_pending = 1'b0;
      @(posedge clk);
      #1;
   endtask : tick
   function automatic logic [39:0] pipe_addr(input int p);
      return {pipe_rx_address.upper, pipe_rx_address[47 - 8 * p -: 8]};
   endfunction : pipe_addr
   // Seen bits: load, ack, ack with payload, transmit done
   task automatic rx_try(input int p, input logic [1:0] pid, input logic na, input logic ok, input logic [3:0] exp);
      logic [3:0] seen;
      seen = 4'h0;
      peer.send(pipe_addr(p), pid, na, 1'b0, ok);
      // Replies stand from the frame edge on, so look before stepping
      repeat (40) begin
         seen |= {rx_fifo_load, air_tx_start & air_tx_is_ack, air_tx_start & air_ack_with_payload, events.tx_done_event};
         if (air_tx_start) check(air_tx_address, pipe_addr(p));
         tick();
      end
      check(seen, exp);
      if (exp[3]) check(rx_pipe, p[2:0]);
   endtask : rx_try
   task automatic tx_go(input logic [1:0] am);
      int n;
      n = 0;
      ack_mode = am;
      tx_fifo_has_packet = 1'b1;
      radio_activate = 1'b1;
      while (air_tx_start !== 1'b1 && n < 11000) begin
         tick();
         n++;
         if (n == 600) radio_activate = 1'b0;
      end
      check(n >= TX_START_CYC && n <= TX_START_CYC + 6, 1'b1);
   endtask : tx_go
   task automatic wait_ev(input int lim, input logic [2:0] exp);
      int n;
      n = 0;
      while (events === 3'h0 && n < lim) begin
         tick();
         n++;
      end
      check(events, exp);
      check({radio_interrupt, tx_fifo_pop}, {1'b1, exp[2]});
      tick();
      tick();
      check(mode, RPE_MODE_STBY1);
   endtask : wait_ev

   task automatic t_rx;
      radio_activate = 1'b1;
      repeat (2) tick();
      check(mode === RPE_MODE_RX, 1'b0);
      repeat (2) tick();
      check(mode, RPE_MODE_RX);
      rx_try(1, 2'h1, 1'b0, 1'b1, 4'hc);
      rx_try(1, 2'h1, 1'b0, 1'b1, 4'h4);
      air_rx_busy = 1'b1;
      rx_try(1, 2'h2, 1'b0, 1'b1, 4'h0);
      air_rx_busy = 1'b0;
      rx_try(2, 2'h1, 1'b0, 1'b1, 4'h0);
      rx_try(0, 2'h2, 1'b1, 1'b1, 4'h8);
      rx_try(1, 2'h2, 1'b0, 1'b0, 4'h0);
      pipe_enable_bits = 6'h3f;
      rx_try(5, 2'h1, 1'b0, 1'b1, 4'hc);
      auto_ack_enable = 1'b0;
      rx_try(2, 2'h1, 1'b0, 1'b1, 4'h8);
      auto_ack_enable = 1'b1;
      ack_payload_pending = 1'b1;
      rx_try(1, 2'h2, 1'b0, 1'b1, 4'he);
      // The confirmed payload is still pending at the frame edge and rides this ack too
      rx_try(1, 2'h3, 1'b0, 1'b1, 4'hf);
      radio_activate = 1'b0;
      repeat (4) tick();
      $display("receive test done");
   endtask : t_rx
   task automatic t_off;
      engine_enable = 1'b0;
      radio_activate = 1'b1;
      repeat (5) tick();
      check(mode, RPE_MODE_STBY1);
      check(crc_force_on, 1'b0);
      radio_activate = 1'b0;
      repeat (4) tick();
      engine_enable = 1'b1;
      repeat (2) tick();
      check(crc_force_on, 1'b1);
      $display("engine off test done");
   endtask : t_off
   task automatic t_tx_ok;
      primary_receiver = 1'b0;
      radio_activate = 1'b1;
      repeat (5) tick();
      check(mode, RPE_MODE_STBY2);
      radio_activate = 1'b0;
      repeat (5) tick();
      tx_go(2'h1);
      wait_ev(200, 3'h4);
      $display("acknowledged send test done");
   endtask : t_tx_ok
   task automatic t_tx_retry;
      int n;
      n = 0;
      tx_go(2'h0);
      // Count from the design's own entry to the ack wait, not from the peer's pulse
      while (mode !== RPE_MODE_RX && n < 100) begin
         tick();
         n++;
      end
      n = 0;
      while (air_tx_start !== 1'b1 && n < 27000) begin
         tick();
         n++;
         if (n == 20000) check(mode, RPE_MODE_STBY2);
         if (n == 20000) ack_mode = 2'h2;
      end
      check(n >= ACK_WAIT_CYC + RETRY_STEP_CYC && n <= ACK_WAIT_CYC + RETRY_STEP_CYC + 10, 1'b1);
      check(retry_count, 4'h1);
      wait_ev(200, 3'h6);
      $display("retry test done");
   endtask : t_tx_retry
   task automatic t_tx_limit;
      retry_limit = 4'h0;
      tx_go(2'h0);
      wait_ev(27000, 3'h1);
      check(tx_fifo_has_packet, 1'b1);
      $display("retry limit test done");
   endtask : t_tx_limit

   initial begin
      rst_b = 1'b0;
      radio_activate = 1'b0;
      primary_receiver = 1'b1;
      engine_enable = 1'b1;
      auto_ack_enable = 1'b1;
      tx_fifo_has_packet = 1'b0;
      ack_payload_pending = 1'b0;
      air_rx_busy = 1'b0;
      retry_delay = 4'h0;
      retry_limit = 4'h3;
      pipe_enable_bits = PIPE_EN_RESET;
      ack_mode = 2'h0;
      pipe_rx_address = {32'h9a4b7c2d, 48'h505152535455};
      repeat (16) @(posedge clk);
      #1 rst_b = 1'b1;
      repeat (4) tick();
      t_rx();
      t_off();
      t_tx_ok();
      t_tx_retry();
      t_tx_limit();
      complete_run();
   end
endmodule : tb_rpe_engine
